// ---- pkg/zone2_pkg.sv ----
// Purpose: shared constants for the remote zone 2 temperature register group
// Assumes: 8-bit two's complement temperatures, one degree per lsb
// Notes:   command codes double as register offsets
package zone2_pkg;
  localparam int unsigned TEMP_W = 8;
  localparam logic [7:0] CMD_REMOTE2_MEASURED  = 8'h20;
  localparam logic [7:0] CMD_REMOTE2_HYSTERESIS = 8'h22;
  localparam logic [7:0] CMD_REMOTE2_SETPOINT  = 8'h23;
  localparam logic [TEMP_W-1:0] RST_MEASURED   = 8'h00;
  localparam logic [TEMP_W-1:0] RST_HYSTERESIS = 8'h5c;
  localparam logic [TEMP_W-1:0] RST_SETPOINT   = 8'h61;
  localparam logic [TEMP_W-1:0] UNMAPPED_READ  = 8'h00;
endpackage

// ---- verilog/remote_zone2_temp_registers.sv ----
// Purpose: remote zone 2 measured, hysteresis and setpoint registers with a link-side access port
// Assumes: the serial engine runs on link_clk and offers one command at a time; converter on ref_clk
// Notes:   access crosses domains by a toggle handshake; held operands stay stable while busy
//
// Functional notes
// - read-only measured temperature register, powers up zero
// - command 20h selects measured temperature register
// - values are 8-bit two's complement degrees
// - measured register loads only after conversions complete
// - hysteresis register, command 22h, resets 5Ch
// - setpoint register, command 23h, resets 61h
`timescale 1ns/1ps
module remote_zone2_temp_registers
  import zone2_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic              conv_valid,
  input  wire logic [TEMP_W-1:0] conv_data,
  input  wire logic              link_clk,
  input  wire logic              acc_strobe,
  input  wire logic [7:0]        acc_cmd,
  input  wire logic              acc_write,
  input  wire logic [TEMP_W-1:0] acc_wdata,
  output logic      [TEMP_W-1:0] acc_rdata,
  output logic                   acc_hit,
  output logic                   acc_busy,
  output logic                   acc_done,
  output logic      [TEMP_W-1:0] remote2_measured_temperature,
  output logic                   over_temp
);

  // signed greater-than on two's complement temperatures
  function automatic logic temp_gt(input logic [TEMP_W-1:0] a, input logic [TEMP_W-1:0] b);
    temp_gt = $signed(a) > $signed(b);
  endfunction

  typedef struct packed {
    logic              req_meta;
    logic              req_sync;
    logic              req_seen;
    logic              ack_tgl;
    logic [TEMP_W-1:0] meas;
    logic [TEMP_W-1:0] hyst;
    logic [TEMP_W-1:0] setp;
    logic [TEMP_W-1:0] rdata;
    logic              hit;
    logic              over;
  } core_s;

  typedef struct packed {
    logic [7:0]        cmd;
    logic              write;
    logic [TEMP_W-1:0] wdata;
    logic              req_tgl;
    logic              ack_meta;
    logic              ack_sync;
    logic              ack_seen;
    logic              busy;
    logic              done;
    logic [TEMP_W-1:0] rdata;
    logic              hit;
  } link_s;

  core_s core_reg;
  core_s core_next;
  link_s link_reg;
  link_s link_next;

  // core domain: register file, converter load, thermostat event
  always_comb begin
    core_next          = core_reg;
    core_next.req_meta = link_reg.req_tgl;
    core_next.req_sync = core_reg.req_meta;
    if (conv_valid) begin
      core_next.meas = conv_data;
    end
    if (core_reg.req_sync != core_reg.req_seen) begin
      // link operands are stable here: the link side holds them until the ack returns
      core_next.req_seen = core_reg.req_sync;
      core_next.ack_tgl  = ~core_reg.ack_tgl;
      core_next.hit      = 1'b1;
      if (link_reg.cmd == CMD_REMOTE2_MEASURED) begin
        core_next.rdata = core_reg.meas;
      end else if (link_reg.cmd == CMD_REMOTE2_HYSTERESIS) begin
        core_next.rdata = core_reg.hyst;
        if (link_reg.write) begin
          core_next.hyst = link_reg.wdata;
        end
      end else if (link_reg.cmd == CMD_REMOTE2_SETPOINT) begin
        core_next.rdata = core_reg.setp;
        if (link_reg.write) begin
          core_next.setp = link_reg.wdata;
        end
      end else begin
        core_next.rdata = UNMAPPED_READ;
        core_next.hit   = 1'b0;
      end
    end
    // set is tested first so a crossing above setpoint is never lost to a release
    if (temp_gt(core_reg.meas, core_reg.setp)) begin
      core_next.over = 1'b1;
    end else if (temp_gt(core_reg.hyst, core_reg.meas)) begin
      core_next.over = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      core_reg          <= '0;
      core_reg.meas     <= RST_MEASURED;
      core_reg.hyst     <= RST_HYSTERESIS;
      core_reg.setp     <= RST_SETPOINT;
      core_reg.rdata    <= UNMAPPED_READ;
    end else begin
      core_reg <= core_next;
    end
  end

  // link domain: capture one command, wait for the core to answer
  always_comb begin
    link_next          = link_reg;
    link_next.ack_meta = core_reg.ack_tgl;
    link_next.ack_sync = link_reg.ack_meta;
    link_next.done     = 1'b0;
    if (link_reg.busy) begin
      if (link_reg.ack_sync != link_reg.ack_seen) begin
        link_next.ack_seen = link_reg.ack_sync;
        link_next.busy     = 1'b0;
        link_next.done     = 1'b1;
        link_next.rdata    = core_reg.rdata;
        link_next.hit      = core_reg.hit;
      end
    end else if (acc_strobe) begin
      // strobes while busy are dropped; the engine must watch acc_busy
      link_next.cmd     = acc_cmd;
      link_next.write   = acc_write;
      link_next.wdata   = acc_wdata;
      link_next.req_tgl = ~link_reg.req_tgl;
      link_next.busy    = 1'b1;
    end
  end

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      link_reg       <= '0;
      link_reg.rdata <= UNMAPPED_READ;
    end else begin
      link_reg <= link_next;
    end
  end

  assign acc_rdata                    = link_reg.rdata;
  assign acc_hit                      = link_reg.hit;
  assign acc_busy                     = link_reg.busy;
  assign acc_done                     = link_reg.done;
  assign remote2_measured_temperature = core_reg.meas;
  assign over_temp                    = core_reg.over;

endmodule

// ---- verification/zone2_monitor.sv ----
// Purpose: port assertions for the zone 2 registers
// Assumes: nrst resets both domains
// Notes: setpoint is internal, so thermostat checks are range limits
`timescale 1ns/1ps
module zone2_monitor
  import zone2_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       conv_valid,
  input wire logic       link_clk,
  input wire logic       acc_strobe,
  input wire logic       acc_write,
  input wire logic       acc_hit,
  input wire logic       acc_busy,
  input wire logic       acc_done,
  input wire logic       over_temp,
  input wire logic [7:0] acc_cmd,
  input wire logic [7:0] conv_data,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] acc_rdata,
  input wire logic [7:0] remote2_measured_temperature
);
  default disable iff (!nrst);
  AST_LOAD: assert property (@(posedge ref_clk) conv_valid |=>
    remote2_measured_temperature == $past(conv_data)) else $error("bad load");
  AST_HOLD: assert property (@(posedge ref_clk) !conv_valid |=>
    $stable(remote2_measured_temperature)) else $error("moved");
  AST_OT: assert property (@(posedge ref_clk) $rose(over_temp) |->
    $past(remote2_measured_temperature) != 8'h80) else $error("bad set");
  AST_BUSY: assert property (@(posedge link_clk) acc_strobe && !acc_busy |=> acc_busy) else $error("no busy");
  AST_DONE: assert property (@(posedge link_clk) $rose(acc_busy) |-> ##[1:8] acc_done) else $error("no done");
  AST_PULSE: assert property (@(posedge link_clk) acc_done |-> !acc_busy ##1 !acc_done) else $error("long");
  AST_UNMAP: assert property (@(posedge link_clk) acc_done && !acc_hit |->
    acc_rdata == UNMAPPED_READ) else $error("unmapped");
  cover property (@(posedge link_clk) acc_done && !acc_hit);
  cover property (@(posedge ref_clk) $rose(over_temp));
  cover property (@(posedge ref_clk) $fell(over_temp));
endmodule

// ---- verification/host_model.sv ----
// Purpose: host stand-in issuing single-byte accesses
// Assumes: link_clk comes from the bench
// Notes: released cmd and wdata lines show the inverse, not the last byte
`timescale 1ns/1ps
module host_model (
  input  wire logic       link_clk,
  input  wire logic       acc_done,
  input  wire logic       acc_hit,
  input  wire logic [7:0] acc_rdata,
  output logic            acc_strobe = 1'b0,
  output logic            acc_write = 1'b0,
  output logic      [7:0] acc_cmd = 8'h00,
  output logic      [7:0] acc_wdata = 8'h00
);
  task automatic access(input logic [7:0] c, input logic w, input logic [7:0] d, output logic [7:0] r, output logic h);
    int n;
    @(posedge link_clk);
    acc_strobe <= 1'b1;
    acc_cmd    <= c;
    acc_write  <= w;
    acc_wdata  <= d;
    @(posedge link_clk);
    acc_strobe <= 1'b0;
    acc_cmd    <= ~c;
    acc_wdata  <= ~d;
    for (n = 0; n < 12 && !acc_done; n++) @(negedge link_clk);
    r = acc_rdata;
    h = acc_hit;
  endtask
endmodule

// ---- verification/remote_zone2_temp_registers_bench.sv ----
// Purpose: self-checking bench for the zone 2 register group
// Assumes: host_model drives the link port
// Notes: rows hold cmd, write, wdata, expected rdata, expected hit
`timescale 1ns/1ps
module remote_zone2_temp_registers_bench;
  import zone2_pkg::*;
  logic       ref_clk = 1'b0, link_clk = 1'b0, nrst = 1'b0, conv_valid = 1'b0, h;
  logic [7:0] conv_data = 8'h00, rd;
  logic       acc_strobe, acc_write, acc_hit, acc_busy, acc_done, over_temp;
  logic [7:0] acc_cmd, acc_wdata, acc_rdata, remote2_measured_temperature;
  int         bad_count = 0, cmp_count = 0;
  logic [39:0] tbl [7] = '{40'h2201205c01, 40'h2200002001, 40'h2301306101, 40'h2300003001,
                           40'h2001550001, 40'h2000000001, 40'h2100000000};
  logic [15:0] th [4] = '{16'hd800, 16'h3101, 16'h2001, 16'h1f00};
  remote_zone2_temp_registers dut_u (.*);
  host_model host_u (.*);
  initial forever #5 ref_clk = ~ref_clk;
  initial begin
    #3;
    forever #24 link_clk = ~link_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic conv(input logic [7:0] d);
    @(posedge ref_clk);
    conv_valid <= 1'b1;
    conv_data  <= d;
    @(posedge ref_clk);
    conv_valid <= 1'b0;
    conv_data  <= ~d;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  initial begin
    #100000;
    bad_count++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge link_clk);
    @(posedge ref_clk) nrst <= 1'b1;
    check(remote2_measured_temperature, RST_MEASURED);
    foreach (tbl[i]) begin
      host_u.access(tbl[i][39:32], tbl[i][24], tbl[i][23:16], rd, h);
      check(rd, tbl[i][15:8]);
      check({7'h00, h}, tbl[i][7:0]);
    end
    $display("register table test done");
    foreach (th[i]) begin
      conv(th[i][15:8]);
      check(remote2_measured_temperature, th[i][15:8]);
      check({7'h00, over_temp}, th[i][7:0]);
    end
    $display("thermostat test done");
    final_report();
  end
endmodule
bind remote_zone2_temp_registers zone2_monitor mon_u (.*);
